// File: core/fab_map.svh
/*
  Register offsets, reset values, field codes and bus constants of the
  fault alert and diagnostic register bank.
  Assumes inclusion by bare name from the bank's design files.
*/
`ifndef FAB_MAP_SVH
`define FAB_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define FAB_OFS_BRIGHT      8'h00
`define FAB_OFS_SINK_CUR    8'h02
`define FAB_OFS_USER_A      8'h04
`define FAB_OFS_USER_B      8'h06
`define FAB_OFS_SUPPLY_EN   8'h08
`define FAB_OFS_CONV_EN     8'h0a
`define FAB_OFS_STRING_EN   8'h0c
`define FAB_OFS_SUPPLY_FLAG 8'h0e
`define FAB_OFS_CONV_FLAG   8'h10
`define FAB_OFS_STRING_FLAG 8'h12
`define FAB_OFS_STATE       8'h14
`define FAB_OFS_IN_DUTY     8'h16
`define FAB_OFS_OUT_DUTY    8'h18
`define FAB_OFS_CUR_CODE    8'h1a
`define FAB_OFS_TARGET      8'h1c
`define FAB_OFS_DETECT      8'h1e

// ----------------------------------------
// reset values and field codes
// ----------------------------------------
`define FAB_RST_CFG         16'h0000
`define FAB_RST_SUPPLY_EN   8'hff
`define FAB_RST_CONV_EN     8'hff
`define FAB_RST_STRING_EN   8'h7f
`define FAB_GLOBAL_IDX      7
`define FAB_EN_READ_ON      2'b10
`define FAB_EN_READ_OFF     2'b01
`define FAB_EN_WR_OFF       2'b01
`define FAB_EN_WR_ON        2'b11
`define FAB_FLAG_CLEAR      2'b11

// ----------------------------------------
// serial link
// ----------------------------------------
`define FAB_I2C_ADDR_BASE   7'h2a
`define FAB_BITS_PER_BYTE   4'h8

`endif

// File: core/fab_pkg.sv
/*
  Types of the fault alert and diagnostic register bank.
  Assumes compilation before every design file of the bank.
*/
package fab_pkg;

  typedef enum logic [2:0] {
    PH_IDLE, PH_DEVADDR, PH_REGADDR, PH_WDATA, PH_ACK, PH_RDATA, PH_MACK
  } fab_phase_t;

  typedef struct packed {
    logic [3:0] outputDimRateDetected;
    logic [3:0] converterRateDetected;
    logic [2:0] stringPhaseDetected;
    logic [1:0] dimModeDetected;
  } fab_straps_t;

  typedef struct packed {
    logic [2:0] ff;
    logic       level;
  } fab_sync_t;

  typedef struct packed {
    fab_phase_t  phase;
    fab_phase_t  ackNext;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic [7:0]  regAddr;
    logic        byteNo;
    logic [7:0]  wrHi;
    logic [15:0] rdShift;
    logic        sdaOe;
    logic        sdaOut;
    logic        sclPrev;
    logic        sdaPrev;
    logic        wrStb;
    logic [15:0] wrData;
    logic [15:0] brightness;
    logic [15:0] sinkCurrent;
    logic [15:0] userA;
    logic [15:0] userB;
    logic [7:0]  supplyEn;
    logic [7:0]  convEn;
    logic [7:0]  stringEn;
    logic [6:0]  supplyFlag;
    logic [7:0]  convFlag;
    logic [7:0]  stringFlag;
    logic [3:0]  presentStateView;
    logic [15:0] inputDutyView;
    logic [15:0] outputDutyView;
    logic [11:0] sinkCurrentCodeView;
    logic [9:0]  converterTargetCode;
    fab_straps_t straps;
    logic        addrSel;
    logic        alertN;
  } fab_core_t;

endpackage

// File: core/fab_pin_sync.sv
/*
  Three-stage input synchroniser with agreement filter for one pin.
  Assumes an idle-high pin, as on an open-drain serial bus.
*/
module fab_pin_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      level
);

  fab_pkg::fab_sync_t st_q;
  fab_pkg::fab_sync_t st_d;

  // the first stage feeds only the second; the filter compares stages two and three
  always_comb begin
    st_d = st_q;
    st_d.ff = {st_q.ff[1:0], pin};
    if (st_q.ff[1] == st_q.ff[2]) begin
      st_d.level = st_q.ff[2];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{ff: 3'h7, level: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.level;

endmodule

// File: core/fab_alert_gate.sv
/*
  Combines fault flags, per-fault enables and the global gate into one
  alert request.
  Assumes registered flags and enables from the register bank.
*/
module fab_alert_gate (
  input  wire logic       globalEn,
  input  wire logic [6:0] supplyFlag,
  input  wire logic [6:0] supplyEn,
  input  wire logic [7:0] convFlag,
  input  wire logic [7:0] convEn,
  input  wire logic [7:0] stringFlag,
  input  wire logic [7:0] stringEn,
  output logic            alertReq
);

  always_comb begin
    alertReq = globalEn & (|(supplyFlag & supplyEn) | |(convFlag & convEn) | // R05 R22
                           |(stringFlag & stringEn));
  end

endmodule

// File: core/fab_regs.sv
/*
  Fault alert and diagnostic register bank with its serial slave port.
  Assumes fault events, state and diagnostic values from logic on clk,
  and serial clock and data from pins outside the clock domain.
*/
// What this block does
// R01: two-bit enable per fault, mostly on after reset
// R02: enabled field reads back binary 10
// R03: writing 01 disables that fault's alert
// R04: writing 11 re-enables that fault's alert
// R05: global gate blocks every alert when off
// R06: diagnostics readable any time, no side effects
// R07: live view of present state
// R08: 16-bit measured input duty readback
// R09: 16-bit applied output duty readback
// R10: 12-bit sink current code readback
// R11: 10-bit converter target code readback
// R12: dimming scheme from mode strap readback
// R13: string phase layout from strap readback
// R14: converter rate from strap readback
// R15: output dimming rate from strap readback
// R16: host leaves reserved offsets alone
// R17: brightness 00h, current 02h, settings 04h/06h
// R18: alert enables at 08h, 0Ah, 0Ch
// R19: status clears when status and clear written
// R20: 8-bit address then two data bytes
// R21: alert pin tells host a fault occurred
// R22: alert follows enabled set flags and gate
`include "fab_map.svh"

module fab_regs (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic             faultAlertN,
  input  wire logic [6:0]  supplyFaultEvt,
  input  wire logic [7:0]  convFaultEvt,
  input  wire logic [7:0]  stringFaultEvt,
  input  wire logic [3:0]  presentState,
  input  wire logic [15:0] inputDuty,
  input  wire logic [15:0] outputDuty,
  input  wire logic [11:0] sinkCurrentCode,
  input  wire logic [9:0]  converterTarget,
  input  wire logic        detectDone,
  input  wire logic [1:0]  dimModeStrap,
  input  wire logic [2:0]  stringLayoutStrap,
  input  wire logic [3:0]  converterRateStrap,
  input  wire logic [3:0]  dimRateStrap,
  input  wire logic        addrSelStrap,
  output logic [15:0]      brightnessLevel,
  output logic [15:0]      sinkCurrentSetting,
  output logic [15:0]      userSettingsA,
  output logic [15:0]      userSettingsB
);

  // ----------------------------------------
  // state and helpers
  // ----------------------------------------
  localparam fab_pkg::fab_core_t CoreRst = '{
    phase:    fab_pkg::PH_IDLE,
    ackNext:  fab_pkg::PH_IDLE,
    sdaOe:    1'b1,
    sclPrev:  1'b1,
    sdaPrev:  1'b1,
    brightness:  `FAB_RST_CFG,
    sinkCurrent: `FAB_RST_CFG,
    userA:    `FAB_RST_CFG,
    userB:    `FAB_RST_CFG,
    supplyEn: `FAB_RST_SUPPLY_EN,
    convEn:   `FAB_RST_CONV_EN,
    stringEn: `FAB_RST_STRING_EN,
    alertN:   1'b1,
    default:  '0
  };

  fab_pkg::fab_core_t st_q;
  fab_pkg::fab_core_t st_d;
  logic               sclF;
  logic               sdaF;
  logic               alertReq;
  logic               sclRise;
  logic               sclFall;
  logic               startCond;
  logic               stopCond;
  logic [1:0]         pinRaw;
  logic [1:0]         pinLvl;
  logic [7:0]         supplyFlagNext;

  // upper six bits of the slave address; the lowest comes from the strap
  localparam logic [6:0] DevBase = `FAB_I2C_ADDR_BASE;

  function automatic logic [15:0] enWord(input logic [7:0] en);
    logic [15:0] w;
    w = '0;
    for (int k = 0; k < 8; k++) begin
      w[2*k +: 2] = en[k] ? `FAB_EN_READ_ON : `FAB_EN_READ_OFF; // R02
    end
    return w;
  endfunction

  // codes 00 and 10 leave the field untouched
  function automatic logic [7:0] applyEn(input logic [7:0] en, input logic [15:0] wd);
    logic [7:0] r;
    r = en;
    for (int k = 0; k < 8; k++) begin
      if (wd[2*k +: 2] == `FAB_EN_WR_OFF) begin
        r[k] = 1'b0; // R03
      end else if (wd[2*k +: 2] == `FAB_EN_WR_ON) begin
        r[k] = 1'b1; // R04
      end
    end
    return r;
  endfunction

  // an event in the clearing cycle keeps its flag set
  function automatic logic [7:0] applyFlag(input logic [7:0] f, input logic [7:0] evt,
                                           input logic clr, input logic [15:0] wd);
    logic [7:0] r;
    r = f;
    for (int k = 0; k < 8; k++) begin
      if (clr && wd[2*k +: 2] == `FAB_FLAG_CLEAR) begin
        r[k] = 1'b0; // R19
      end
      if (evt[k]) begin
        r[k] = 1'b1;
      end
    end
    return r;
  endfunction

  // clear bits always read as zero
  function automatic logic [15:0] flagWord(input logic [7:0] f);
    logic [15:0] w;
    w = '0;
    for (int k = 0; k < 8; k++) begin
      w[2*k] = f[k];
    end
    return w;
  endfunction

  // snapshot at the address phase keeps both bytes of a read coherent
  function automatic logic [15:0] readWord(input fab_pkg::fab_core_t s);
    logic [15:0] w;
    w = '0;
    case (s.regAddr) // R06 R17 R18
      `FAB_OFS_BRIGHT:      w = s.brightness;
      `FAB_OFS_SINK_CUR:    w = s.sinkCurrent;
      `FAB_OFS_USER_A:      w = s.userA;
      `FAB_OFS_USER_B:      w = s.userB;
      `FAB_OFS_SUPPLY_EN:   w = enWord(s.supplyEn);
      `FAB_OFS_CONV_EN:     w = enWord(s.convEn);
      `FAB_OFS_STRING_EN:   w = enWord(s.stringEn);
      `FAB_OFS_SUPPLY_FLAG: w = flagWord({1'b0, s.supplyFlag});
      `FAB_OFS_CONV_FLAG:   w = flagWord(s.convFlag);
      `FAB_OFS_STRING_FLAG: w = flagWord(s.stringFlag);
      `FAB_OFS_STATE:       w = {12'h000, s.presentStateView}; // R07
      `FAB_OFS_IN_DUTY:     w = s.inputDutyView; // R08
      `FAB_OFS_OUT_DUTY:    w = s.outputDutyView; // R09
      `FAB_OFS_CUR_CODE:    w = {4'h0, s.sinkCurrentCodeView}; // R10
      `FAB_OFS_TARGET:      w = {6'h00, s.converterTargetCode}; // R11
      `FAB_OFS_DETECT:      w = {3'h0, s.straps}; // R12 R13 R14 R15
      default:              w = '0;
    endcase
    return w;
  endfunction

  // ----------------------------------------
  // pin synchronisers and alert gate
  // ----------------------------------------
  assign pinRaw = {sdaIn, sclIn};

  for (genvar g = 0; g < 2; g++) begin : gSync
    fab_pin_sync uSync (
      .clk   (clk),
      .rstn  (rstn),
      .pin   (pinRaw[g]),
      .level (pinLvl[g])
    );
  end

  assign sclF = pinLvl[0];
  assign sdaF = pinLvl[1];
  assign sclRise = sclF & ~st_q.sclPrev;
  assign sclFall = ~sclF & st_q.sclPrev;
  assign startCond = sclF & st_q.sclPrev & st_q.sdaPrev & ~sdaF;
  assign stopCond = sclF & st_q.sclPrev & ~st_q.sdaPrev & sdaF;
  assign supplyFlagNext = applyFlag({1'b0, st_q.supplyFlag}, {1'b0, supplyFaultEvt},
                                    st_q.wrStb && st_q.regAddr == `FAB_OFS_SUPPLY_FLAG, st_q.wrData);

  fab_alert_gate uGate (
    .globalEn   (st_q.supplyEn[`FAB_GLOBAL_IDX]),
    .supplyFlag (st_q.supplyFlag),
    .supplyEn   (st_q.supplyEn[6:0]),
    .convFlag   (st_q.convFlag),
    .convEn     (st_q.convEn),
    .stringFlag (st_q.stringFlag),
    .stringEn   (st_q.stringEn),
    .alertReq   (alertReq)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.wrStb = 1'b0;
    st_d.sdaOut = 1'b0;
    st_d.sclPrev = sclF;
    st_d.sdaPrev = sdaF;
    st_d.presentStateView = presentState; // R07
    st_d.inputDutyView = inputDuty; // R08
    st_d.outputDutyView = outputDuty; // R09
    st_d.sinkCurrentCodeView = sinkCurrentCode; // R10
    st_d.converterTargetCode = converterTarget; // R11
    if (detectDone) begin
      st_d.straps = '{outputDimRateDetected: dimRateStrap, // R15
                      converterRateDetected: converterRateStrap, // R14
                      stringPhaseDetected:   stringLayoutStrap, // R13
                      dimModeDetected:       dimModeStrap}; // R12
      st_d.addrSel = addrSelStrap;
    end

    // writes to reserved or read-only offsets are dropped
    if (st_q.wrStb) begin
      case (st_q.regAddr) // R17 R18
        `FAB_OFS_BRIGHT:    st_d.brightness = st_q.wrData;
        `FAB_OFS_SINK_CUR:  st_d.sinkCurrent = st_q.wrData;
        `FAB_OFS_USER_A:    st_d.userA = st_q.wrData;
        `FAB_OFS_USER_B:    st_d.userB = st_q.wrData;
        `FAB_OFS_SUPPLY_EN: st_d.supplyEn = applyEn(st_q.supplyEn, st_q.wrData);
        `FAB_OFS_CONV_EN:   st_d.convEn = applyEn(st_q.convEn, st_q.wrData);
        `FAB_OFS_STRING_EN: st_d.stringEn = applyEn(st_q.stringEn, st_q.wrData);
        default: ;
      endcase
    end
    st_d.supplyFlag = supplyFlagNext[6:0];
    st_d.convFlag = applyFlag(st_q.convFlag, convFaultEvt,
                              st_q.wrStb && st_q.regAddr == `FAB_OFS_CONV_FLAG, st_q.wrData);
    st_d.stringFlag = applyFlag(st_q.stringFlag, stringFaultEvt,
                                st_q.wrStb && st_q.regAddr == `FAB_OFS_STRING_FLAG, st_q.wrData);
    st_d.alertN = ~alertReq; // R21 R22

    // serial slave: start, address, register address, two data bytes
    if (startCond) begin
      st_d.phase = fab_pkg::PH_DEVADDR;
      st_d.bitCnt = '0;
      st_d.sdaOe = 1'b1;
    end else if (stopCond) begin
      st_d.phase = fab_pkg::PH_IDLE;
      st_d.sdaOe = 1'b1;
    end else if (sclRise) begin
      case (st_q.phase)
        fab_pkg::PH_DEVADDR, fab_pkg::PH_REGADDR, fab_pkg::PH_WDATA: begin
          if (st_q.bitCnt < `FAB_BITS_PER_BYTE) begin
            st_d.shift = {st_q.shift[6:0], sdaF};
            st_d.bitCnt = st_q.bitCnt + 4'h1;
          end
        end
        fab_pkg::PH_RDATA: begin
          st_d.bitCnt = st_q.bitCnt + 4'h1;
          st_d.rdShift = {st_q.rdShift[14:0], 1'b0};
        end
        fab_pkg::PH_MACK: begin
          if (sdaF) begin
            st_d.phase = fab_pkg::PH_IDLE;
          end
        end
        default: ;
      endcase
    end else if (sclFall) begin
      case (st_q.phase)
        fab_pkg::PH_DEVADDR: begin
          if (st_q.bitCnt == `FAB_BITS_PER_BYTE) begin
            if (st_q.shift[7:1] == {DevBase[6:1], st_q.addrSel}) begin
              st_d.phase = fab_pkg::PH_ACK;
              st_d.sdaOe = 1'b0;
              st_d.ackNext = st_q.shift[0] ? fab_pkg::PH_RDATA : fab_pkg::PH_REGADDR;
              st_d.rdShift = readWord(st_q); // R06
            end else begin
              st_d.phase = fab_pkg::PH_IDLE;
            end
          end
        end
        fab_pkg::PH_REGADDR: begin
          if (st_q.bitCnt == `FAB_BITS_PER_BYTE) begin
            st_d.regAddr = st_q.shift; // R20
            st_d.byteNo = 1'b0;
            st_d.phase = fab_pkg::PH_ACK;
            st_d.sdaOe = 1'b0;
            st_d.ackNext = fab_pkg::PH_WDATA;
          end
        end
        fab_pkg::PH_WDATA: begin
          if (st_q.bitCnt == `FAB_BITS_PER_BYTE) begin
            st_d.phase = fab_pkg::PH_ACK;
            st_d.sdaOe = 1'b0;
            if (!st_q.byteNo) begin
              st_d.wrHi = st_q.shift; // R20
              st_d.byteNo = 1'b1;
              st_d.ackNext = fab_pkg::PH_WDATA;
            end else begin
              st_d.wrStb = 1'b1;
              st_d.wrData = {st_q.wrHi, st_q.shift}; // R20
              st_d.ackNext = fab_pkg::PH_IDLE;
            end
          end
        end
        fab_pkg::PH_ACK: begin
          st_d.phase = st_q.ackNext;
          st_d.bitCnt = '0;
          st_d.sdaOe = (st_q.ackNext == fab_pkg::PH_RDATA) ? st_q.rdShift[15] : 1'b1;
        end
        fab_pkg::PH_RDATA: begin
          if (st_q.bitCnt == `FAB_BITS_PER_BYTE) begin
            st_d.phase = fab_pkg::PH_MACK;
            st_d.bitCnt = '0;
            st_d.sdaOe = 1'b1;
          end else begin
            st_d.sdaOe = st_q.rdShift[15];
          end
        end
        fab_pkg::PH_MACK: begin
          st_d.phase = fab_pkg::PH_RDATA;
          st_d.sdaOe = st_q.rdShift[15];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= CoreRst; // R01
    end else begin
      st_q <= st_d;
    end
  end

  assign sdaOut = st_q.sdaOut;
  assign sdaOe = st_q.sdaOe;
  assign faultAlertN = st_q.alertN;
  assign brightnessLevel = st_q.brightness;
  assign sinkCurrentSetting = st_q.sinkCurrent;
  assign userSettingsA = st_q.userA;
  assign userSettingsB = st_q.userB;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_global_gate: assert property (!st_q.supplyEn[`FAB_GLOBAL_IDX] |=> faultAlertN) // R05
    else $error("alert asserted with global gate off");
  chk_alert_follow: assert property (faultAlertN == !$past(alertReq)) // R22
    else $error("alert pin does not follow enabled flags");
  chk_disable_write: assert property (st_q.wrStb && st_q.regAddr == `FAB_OFS_CONV_EN && // R03
      st_q.wrData[1:0] == `FAB_EN_WR_OFF |=> !st_q.convEn[0])
    else $error("writing 01 did not disable the alert");
  chk_enable_write: assert property (st_q.wrStb && st_q.regAddr == `FAB_OFS_SUPPLY_EN && // R04
      st_q.wrData[1:0] == `FAB_EN_WR_ON |=> st_q.supplyEn[0])
    else $error("writing 11 did not enable the alert");
  chk_enable_read: assert property (st_q.phase == fab_pkg::PH_ACK && // R02
      st_q.ackNext == fab_pkg::PH_RDATA && st_q.regAddr == `FAB_OFS_SUPPLY_EN |->
      st_q.rdShift[1:0] == (st_q.supplyEn[0] ? `FAB_EN_READ_ON : `FAB_EN_READ_OFF))
    else $error("enable field readback code wrong");
  chk_clear_pair: assert property (st_q.wrStb && st_q.regAddr == `FAB_OFS_SUPPLY_FLAG && // R19
      st_q.wrData[1:0] == `FAB_FLAG_CLEAR && !supplyFaultEvt[0] |=> !st_q.supplyFlag[0])
    else $error("status not cleared by status and clear write");
  chk_set_wins: assert property (convFaultEvt[0] |=> st_q.convFlag[0]) // R19
    else $error("fault event lost");
  chk_state_live: assert property ($past(rstn) |-> st_q.presentStateView == $past(presentState)) // R07
    else $error("state view lags the state machine");
  chk_strap_hold: assert property (!detectDone |=> $stable(st_q.straps)) // R12
    else $error("strap result changed without detection");
  chk_idle_release: assert property (st_q.phase == fab_pkg::PH_IDLE |-> sdaOe) // R20
    else $error("data line driven while idle");

  cov_write: cover property (st_q.wrStb ##1 st_q.phase == fab_pkg::PH_IDLE);
  cov_read: cover property (st_q.phase == fab_pkg::PH_RDATA ##[1:400] st_q.phase == fab_pkg::PH_MACK);
  cov_alert: cover property (!faultAlertN);
  cov_clear: cover property (!faultAlertN ##[1:1000] faultAlertN);

endmodule

// File: testbench/fab_host_model.sv
/*
  Behavioural host on the serial register link of the alert bank.
  Assumes the bench feeds back the wired-and of host and device data.
*/
module fab_host_model (
  input  wire logic clk,
  input  wire logic sdaLine,
  output logic      sclPin,
  output logic      sdaPin
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // bit level
  // ----------------------------------------
  int unsigned halfBit = 10;

  initial begin
    sclPin = 1'b1;
    sdaPin = 1'b1;
  end

  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // data held 6 clk past the fall: the device sees pins 4 clk late
  task automatic bitOut(input logic b);
    sdaPin <= b;
    waitClk(halfBit);
    sclPin <= 1'b1;
    waitClk(halfBit);
    sclPin <= 1'b0;
    waitClk(6);
  endtask

  task automatic bitIn(output logic b);
    sdaPin <= 1'b1;
    waitClk(halfBit);
    sclPin <= 1'b1;
    waitClk(halfBit - 2);
    b = sdaLine;
    waitClk(2);
    sclPin <= 1'b0;
    waitClk(6);
  endtask

  // ----------------------------------------
  // framing
  // ----------------------------------------
  task automatic start();
    sdaPin <= 1'b1;
    waitClk(halfBit);
    sclPin <= 1'b1;
    waitClk(halfBit);
    sdaPin <= 1'b0;
    waitClk(halfBit);
    sclPin <= 1'b0;
    waitClk(6);
  endtask

  task automatic stop();
    sdaPin <= 1'b0;
    waitClk(halfBit);
    sclPin <= 1'b1;
    waitClk(halfBit);
    sdaPin <= 1'b1;
    waitClk(halfBit);
  endtask

  task automatic byteOut(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitOut(v[i]);
    end
    bitIn(a);
    ack = !a;
  endtask

  task automatic byteIn(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      bitIn(v[i]);
    end
    bitOut(last);
  endtask

  // ----------------------------------------
  // register transfers
  // ----------------------------------------
  task automatic write16(input logic [6:0] dev, input logic [7:0] ofs, input logic [15:0] d, output logic ack);
    logic [3:0] a;
    start();
    byteOut({dev, 1'b0}, a[0]);
    byteOut(ofs, a[1]);
    byteOut(d[15:8], a[2]);
    byteOut(d[7:0], a[3]);
    stop();
    ack = &a;
  endtask

  task automatic read16(input logic [6:0] dev, input logic [7:0] ofs, output logic [15:0] d);
    logic a;
    start();
    byteOut({dev, 1'b0}, a);
    byteOut(ofs, a);
    start();
    byteOut({dev, 1'b1}, a);
    byteIn(1'b0, d[15:8]);
    byteIn(1'b1, d[7:0]);
    stop();
  endtask
endmodule

// File: testbench/testbench.sv
/*
  Self-checking bench of the fault alert and diagnostic register bank.
  Assumes the host model above and a pull-up on the serial data line.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  ofs;
    logic        wr;
    logic [15:0] wd;
    logic [15:0] exp;
  } fab_row_t;

  logic clk, rstn, sclPin, sdaPin, sdaLine, sdaOut, sdaOe, faultAlertN, detectDone, addrSelStrap, ack;
  logic [6:0]  supplyFaultEvt, devAddr;
  logic [7:0]  convFaultEvt, stringFaultEvt;
  logic [3:0]  presentState, converterRateStrap, dimRateStrap;
  logic [15:0] inputDuty, outputDuty, brightnessLevel, sinkCurrentSetting, userSettingsA, userSettingsB, rd;
  logic [11:0] sinkCurrentCode;
  logic [9:0]  converterTarget;
  logic [1:0]  dimModeStrap;
  logic [2:0]  stringLayoutStrap;
  int          miscompares, checked, cycles;

  fab_row_t rows [15] = '{
    '{8'h08, 1'b0, 16'h0000, 16'haaaa}, '{8'h0a, 1'b0, 16'h0000, 16'haaaa},
    '{8'h0c, 1'b0, 16'h0000, 16'h6aaa}, '{8'h00, 1'b1, 16'h1234, 16'h1234},
    '{8'h02, 1'b1, 16'ha5c3, 16'ha5c3}, '{8'h04, 1'b1, 16'hffff, 16'hffff},
    '{8'h06, 1'b1, 16'h8001, 16'h8001}, '{8'h0a, 1'b1, 16'h0201, 16'haaa9},
    '{8'h0a, 1'b1, 16'h0003, 16'haaaa}, '{8'h14, 1'b1, 16'hffff, 16'h0005},
    '{8'h16, 1'b0, 16'h0000, 16'hbeef}, '{8'h18, 1'b0, 16'h0000, 16'h1357},
    '{8'h1a, 1'b0, 16'h0000, 16'h0abc}, '{8'h1c, 1'b0, 16'h0000, 16'h02f1},
    '{8'h20, 1'b0, 16'h0000, 16'h0000}};

  assign sdaLine = sdaPin & (sdaOe | sdaOut);

  fab_host_model host_i (.clk(clk), .sdaLine(sdaLine), .sclPin(sclPin), .sdaPin(sdaPin));

  fab_regs fab_regs_i (
    .clk(clk), .rstn(rstn), .sclIn(sclPin), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .faultAlertN(faultAlertN), .supplyFaultEvt(supplyFaultEvt), .convFaultEvt(convFaultEvt),
    .stringFaultEvt(stringFaultEvt), .presentState(presentState), .inputDuty(inputDuty),
    .outputDuty(outputDuty), .sinkCurrentCode(sinkCurrentCode), .converterTarget(converterTarget),
    .detectDone(detectDone), .dimModeStrap(dimModeStrap), .stringLayoutStrap(stringLayoutStrap),
    .converterRateStrap(converterRateStrap), .dimRateStrap(dimRateStrap), .addrSelStrap(addrSelStrap),
    .brightnessLevel(brightnessLevel), .sinkCurrentSetting(sinkCurrentSetting),
    .userSettingsA(userSettingsA), .userSettingsB(userSettingsB));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [15:0] d);
    host_i.write16(devAddr, ofs, d, ack);
    check({15'h0, ack}, 16'h0001);
  endtask

  task automatic rdCheck(input logic [7:0] ofs, input logic [15:0] exp);
    host_i.read16(devAddr, ofs, rd);
    check(rd, exp);
  endtask

  task automatic alertIs(input logic lvl);
    check({15'h0, faultAlertN}, {15'h0, lvl});
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // about 35 transfers of 1000 to 1300 clk each
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    {rstn, detectDone, addrSelStrap, supplyFaultEvt, convFaultEvt, stringFaultEvt} = '0;
    {dimModeStrap, stringLayoutStrap, converterRateStrap, dimRateStrap} = '0;
    presentState = 4'h5;
    inputDuty = 16'hbeef;
    outputDuty = 16'h1357;
    sinkCurrentCode = 12'habc;
    converterTarget = 10'h2f1;
    devAddr = 7'h2a;
    miscompares = 0;
    checked = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].ofs, rows[i].wd);
      rdCheck(rows[i].ofs, rows[i].exp);
    end
    check(brightnessLevel, 16'h1234);
    check(userSettingsB, 16'h8001);
    check(sinkCurrentSetting, 16'ha5c3);
    check(userSettingsA, 16'hffff);
    alertIs(1'b1);
    supplyFaultEvt <= 7'h01;
    @(posedge clk);
    supplyFaultEvt <= 7'h00;
    repeat (4) @(posedge clk);
    alertIs(1'b0);
    rdCheck(8'h0e, 16'h0001);
    wr(8'h08, 16'h0001);
    alertIs(1'b1);
    wr(8'h08, 16'h0003);
    alertIs(1'b0);
    wr(8'h08, 16'h4000);
    alertIs(1'b1);
    wr(8'h08, 16'hc000);
    alertIs(1'b0);
    // a clear bit alone must leave the flag set
    wr(8'h0e, 16'h0002);
    alertIs(1'b0);
    wr(8'h0e, 16'h0003);
    alertIs(1'b1);
    rdCheck(8'h0e, 16'h0000);
    stringFaultEvt <= 8'h80;
    @(posedge clk);
    stringFaultEvt <= 8'h00;
    repeat (4) @(posedge clk);
    alertIs(1'b1);
    rdCheck(8'h12, 16'h4000);
    // strap capture also moves the slave address to the odd one
    {dimModeStrap, stringLayoutStrap, converterRateStrap, dimRateStrap, addrSelStrap} <= {2'h2, 3'h5, 4'h9, 4'h6, 1'b1};
    detectDone <= 1'b1;
    @(posedge clk);
    detectDone <= 1'b0;
    repeat (2) @(posedge clk);
    devAddr = 7'h2b;
    rdCheck(8'h1e, 16'h0d36);
    host_i.write16(7'h2a, 8'h00, 16'h5555, ack);
    check({15'h0, ack}, 16'h0000);
    check(brightnessLevel, 16'h1234);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    check(brightnessLevel, 16'h0000);
    alertIs(1'b1);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    devAddr = 7'h2a;
    rdCheck(8'h0c, 16'h6aaa);
    report_and_stop();
  end
endmodule
